//--- inc/acc_pkg.sv
// Constants shared by the analog comparator control logic.
package acc_pkg;
    // ==========================================================
    // Register bus
    localparam int          ADDR_W        = 2;
    localparam int          DATA_W        = 8;
    localparam logic [1:0]  REG_CMP_CSR   = 2'h0;
    localparam logic [1:0]  REG_CONV_B    = 2'h1;
    localparam logic [1:0]  REG_IN_DIS    = 2'h2;

    // ==========================================================
    // Comparator control and status fields
    localparam int          BIT_PWR_OFF   = 7;
    localparam int          BIT_REF_SEL   = 6;
    localparam int          BIT_RESULT    = 5;
    localparam int          BIT_EVT_FLAG  = 4;
    localparam int          BIT_IRQ_EN    = 3;
    localparam int          BIT_RSVD      = 2;
    localparam int          BIT_MODE_HI   = 1;
    localparam int          BIT_MODE_LO   = 0;
    localparam logic [7:0]  CSR_RESET     = 8'h00;
    localparam logic [7:0]  CSR_STORE     = 8'hcb;

    // ==========================================================
    // Converter control B fields
    localparam int          BIT_NEG_MUX   = 6;
    localparam logic [7:0]  CONVB_RESET   = 8'h00;
    localparam logic [7:0]  CONVB_STORE   = 8'h47;

    // ==========================================================
    // Digital input disable fields
    localparam int          PIN_COUNT     = 6;
    localparam logic [7:0]  IN_DIS_RESET  = 8'h00;
    localparam logic [7:0]  IN_DIS_STORE  = 8'h3f;

    // ==========================================================
    // Event modes
    localparam logic [1:0]  MODE_TOGGLE   = 2'h0;
    localparam logic [1:0]  MODE_RSVD     = 2'h1;
    localparam logic [1:0]  MODE_FALL     = 2'h2;
    localparam logic [1:0]  MODE_RISE     = 2'h3;

    // ==========================================================
    // Synchroniser and reference selection
    localparam int          SYNC_STAGES   = 2;
    localparam int          REF_HI_BIT    = 1;
endpackage

//--- design/acc_sync.sv
// Two-stage synchroniser for the raw comparator decision.
`timescale 1ns/10ps
`default_nettype none
module acc_sync (
    input  wire logic clk_i,     // System clock
    input  wire logic sys_rst_i, // Synchronous reset, active high
    input  wire logic async_i,   // Raw level
    output logic      sync_o     // Synchronised level
);
    import acc_pkg::*;

    logic meta;

    // The first stage is read only by the second stage.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            meta   <= 1'b0;
            sync_o <= 1'b0;
        end else begin
            meta   <= async_i;
            sync_o <= meta;
        end
    end
endmodule
`default_nettype wire

//--- design/acc_ctrl.sv
// Analog comparator control: input muxing, result sync, events, registers.
`timescale 1ns/10ps
`default_nettype none
module acc_ctrl #(
    parameter int          VW     = 10,     // Width of a level code
    parameter logic [9:0]  REF_LO = 10'h119, // Lower internal reference code
    parameter logic [9:0]  REF_HI = 10'h28f  // Higher internal reference code
) (
    input  wire logic                    clk_i,         // System clock
    input  wire logic                    sys_rst_i,     // Sync reset
    input  wire logic [acc_pkg::ADDR_W-1:0] addr_i,     // Register index
    input  wire logic [acc_pkg::DATA_W-1:0] wdata_i,    // Write data
    input  wire logic                    wr_i,          // Write strobe
    input  wire logic                    rd_i,          // Read strobe
    output logic [acc_pkg::DATA_W-1:0]   rdata_o,       // Read data
    input  wire logic [VW-1:0]           pos_pin_i,     // Positive pin level
    input  wire logic [VW-1:0]           neg_pin_i,     // Negative pin level
    input  wire logic [3:0][VW-1:0]      chan_i,        // Channel pin levels
    input  wire logic                    converter_enable_i, // Converter on
    input  wire logic [1:0]              channel_select_low_i, // Channel
    input  wire logic [2:0]              reference_level_select_i, // Ref
    input  wire logic                    global_irq_en_i, // Core enable
    input  wire logic                    irq_vector_ack_i, // Vector taken
    input  wire logic [acc_pkg::PIN_COUNT-1:0] pad_in_i, // Pad levels
    output logic [acc_pkg::PIN_COUNT-1:0] port_in_o,    // Port bits
    output logic [acc_pkg::PIN_COUNT-1:0] buf_off_o,    // Buffer off
    output logic                         comparator_power_off_o, // Off
    output logic                         irq_o          // Interrupt
);
    import acc_pkg::*;

    // ==========================================================
    // Register state
    logic [7:0]    csr;
    logic [7:0]    convb;
    logic [7:0]    in_dis;
    logic          compare_event_flag;
    logic          compare_result_bit;
    logic          result_prev;
    logic          raw_result;
    logic [VW-1:0] pos_level;
    logic [VW-1:0] neg_level;
    logic          neg_from_chan;
    logic          set_event;
    logic          rise;
    logic          fall;
    logic          wr_csr;

    logic          comparator_power_off;
    logic          internal_ref_select;
    logic          compare_irq_enable;
    logic [1:0]    event_mode;
    logic          negative_mux_enable;

    assign comparator_power_off = csr[BIT_PWR_OFF];
    assign internal_ref_select  = csr[BIT_REF_SEL];
    assign compare_irq_enable   = csr[BIT_IRQ_EN];
    assign event_mode = {csr[BIT_MODE_HI], csr[BIT_MODE_LO]};
    assign negative_mux_enable  = convb[BIT_NEG_MUX];

    // Pure decode: a continuous assignment only wakes on its own operands.
    function automatic logic hit(input logic [1:0] a,
                                 input logic [1:0] r);
        hit = (a == r);
    endfunction

    assign wr_csr = wr_i && hit(addr_i, REG_CMP_CSR);

    // ==========================================================
    // Register writes
    // Only stored bits are kept; the flag and result live apart.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            csr <= CSR_RESET;
        end else if (wr_csr) begin
            csr <= wdata_i & CSR_STORE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            convb <= CONVB_RESET;
        end else if (wr_i && hit(addr_i, REG_CONV_B)) begin
            convb <= wdata_i & CONVB_STORE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            in_dis <= IN_DIS_RESET;
        end else if (wr_i && hit(addr_i, REG_IN_DIS)) begin
            in_dis <= wdata_i & IN_DIS_STORE;
        end
    end

    // ==========================================================
    // Register reads
    // An unmapped index reads as zero.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            case (addr_i)
                REG_CMP_CSR: begin
                    rdata_o <= (csr & CSR_STORE)
                             | ({7'h00, compare_result_bit} << BIT_RESULT)
                             | ({7'h00, compare_event_flag} << BIT_EVT_FLAG);
                end
                REG_CONV_B: begin
                    rdata_o <= convb & CONVB_STORE;
                end
                REG_IN_DIS: begin
                    rdata_o <= in_dis & IN_DIS_STORE;
                end
                default: begin
                    rdata_o <= 8'h00;
                end
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end

    // ==========================================================
    // Input selection
    // The higher reference is taken when the select field's bit 1 is set.
    always_comb begin
        if (internal_ref_select) begin
            pos_level = reference_level_select_i[REF_HI_BIT]
                      ? REF_HI[VW-1:0] : REF_LO[VW-1:0];
        end else begin
            pos_level = pos_pin_i;
        end
    end

    // The converter owns its multiplexer while it runs.
    assign neg_from_chan = negative_mux_enable && !converter_enable_i;

    always_comb begin
        if (neg_from_chan) begin
            neg_level = chan_i[channel_select_low_i];
        end else begin
            neg_level = neg_pin_i;
        end
    end

    // ==========================================================
    // Comparator
    // A powered-off comparator rests low, so leaving power-off can
    // look like a rising edge; software masks the interrupt first.
    assign raw_result = !comparator_power_off
                     && (pos_level > neg_level);

    acc_sync u_sync (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .async_i   (raw_result),
        .sync_o    (compare_result_bit)
    );

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            result_prev <= 1'b0;
        end else begin
            result_prev <= compare_result_bit;
        end
    end

    assign rise = compare_result_bit && !result_prev;
    assign fall = !compare_result_bit && result_prev;

    always_comb begin
        case (event_mode)
            MODE_TOGGLE: set_event = rise || fall;
            MODE_FALL:   set_event = fall;
            MODE_RISE:   set_event = rise;
            default:     set_event = 1'b0;
        endcase
    end

    // ==========================================================
    // Event flag and interrupt
    // A new event wins over a clear in the same cycle.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            compare_event_flag <= 1'b0;
        end else if (set_event) begin
            compare_event_flag <= 1'b1;
        end else if (irq_vector_ack_i
                     || (wr_csr && wdata_i[BIT_EVT_FLAG])) begin
            compare_event_flag <= 1'b0;
        end
    end

    assign irq_o = compare_event_flag && compare_irq_enable
                && global_irq_en_i;

    assign comparator_power_off_o = comparator_power_off;

    // ==========================================================
    // Digital input buffers
    // Bit order of the pads follows the disable register.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            port_in_o <= '0;
            buf_off_o <= '0;
        end else begin
            port_in_o <= pad_in_i & ~in_dis[PIN_COUNT-1:0];
            buf_off_o <= in_dis[PIN_COUNT-1:0];
        end
    end

    // ==========================================================
    // Checks
    raw_compare_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        !comparator_power_off |-> raw_result == (pos_level > neg_level))
        else $error("raw result does not follow the levels");

    sync_lag_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (!$past(sys_rst_i) && !$past(sys_rst_i, 2)) |->
        compare_result_bit == $past(raw_result, 2))
        else $error("result bit does not lag raw by two cycles");

    rise_only_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (event_mode == MODE_RISE && fall && !compare_event_flag)
        |=> !compare_event_flag)
        else $error("falling edge set flag in rise mode");

    toggle_set_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (event_mode == MODE_TOGGLE && (rise || fall))
        |=> compare_event_flag)
        else $error("toggle did not set the flag");

    ack_clear_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (irq_vector_ack_i && !set_event) |=> !compare_event_flag)
        else $error("acknowledge did not clear the flag");

    irq_gate_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        irq_o |-> compare_event_flag && csr[BIT_IRQ_EN]
               && global_irq_en_i)
        else $error("interrupt raised without all enables");

    power_off_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        comparator_power_off [*3] |-> !compare_result_bit)
        else $error("result high while powered off");

    ref_route_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        !internal_ref_select |-> pos_level == pos_pin_i)
        else $error("positive pin not routed");

    neg_route_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (negative_mux_enable && converter_enable_i)
        |-> neg_level == neg_pin_i)
        else $error("negative pin not routed while converter on");

    rsvd_zero_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (rd_i && addr_i == REG_CMP_CSR) |=> !rdata_o[BIT_RSVD])
        else $error("reserved bit read as one");

    power_bit_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        wr_csr |=> comparator_power_off_o == $past(wdata_i[BIT_PWR_OFF]))
        else $error("power-off bit not at bit 7");

    convb_zero_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (rd_i && addr_i == REG_CONV_B) |=> rdata_o[5:3] == 3'h0)
        else $error("converter register bits 5 to 3 not zero");

    pin_force_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        in_dis[0] |=> !port_in_o[0])
        else $error("disabled pin reads one");

    dis_top_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (rd_i && addr_i == REG_IN_DIS) |=> rdata_o[7:6] == 2'h0)
        else $error("input disable bits 7 and 6 not zero");

    once_only_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (compare_result_bit == result_prev && !compare_event_flag)
        |=> !compare_event_flag)
        else $error("flag set without a transition");

    fall_only_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (event_mode == MODE_FALL && rise && !compare_event_flag) |=> !compare_event_flag)
        else $error("rising edge set flag in fall mode");

    rsvd_mode_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (event_mode == MODE_RSVD && !compare_event_flag) |=> !compare_event_flag)
        else $error("reserved mode set the flag");

    write_clear_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (wr_csr && wdata_i[BIT_EVT_FLAG] && !set_event) |=> !compare_event_flag)
        else $error("written one did not clear the flag");

    chan_route_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (negative_mux_enable && !converter_enable_i)
        |-> neg_level == chan_i[channel_select_low_i])
        else $error("selected channel not routed");

    ref_level_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (internal_ref_select && reference_level_select_i[REF_HI_BIT])
        |-> pos_level == REF_HI[VW-1:0])
        else $error("higher reference not routed");

    csr_view_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (rd_i && addr_i == REG_CMP_CSR) |=>
        rdata_o[BIT_RESULT] == $past(compare_result_bit)
        && rdata_o[BIT_EVT_FLAG] == $past(compare_event_flag))
        else $error("result or flag misplaced in read data");

    read_idle_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        !rd_i |=> rdata_o == 8'h00)
        else $error("read data not zero without a read");
endmodule
`default_nettype wire

//--- verif/acc_ctrl_tb.sv
// Self-checking testbench for the analog comparator control block.
`timescale 1ns/10ps
`default_nettype none
module acc_ctrl_tb;
    import acc_pkg::*;
    typedef struct packed {
        logic [1:0] a;
        logic [7:0] w;
        logic [7:0] r;
        logic [5:0] p;
    } acc_row_t;

    logic             clk_i = 1'b0;
    logic             sys_rst_i = 1'b1;
    logic [1:0]       addr_i = 2'h0;
    logic [7:0]       wdata_i = 8'h00;
    logic             wr_i = 1'b0;
    logic             rd_i = 1'b0;
    logic [7:0]       rdata_o;
    logic [9:0]       pos_pin_i = 10'h100;
    logic [9:0]       neg_pin_i = 10'h200;
    logic [3:0][9:0]  chan_i = {10'h280, 10'h180, 10'h380, 10'h080};
    logic             converter_enable_i = 1'b0;
    logic [1:0]       channel_select_low_i = 2'h0;
    logic [2:0]       reference_level_select_i = 3'h0;
    logic             global_irq_en_i = 1'b1;
    logic             irq_vector_ack_i = 1'b0;
    logic [5:0]       pad_in_i = 6'h3f;
    logic [5:0]       port_in_o;
    logic [5:0]       buf_off_o;
    logic             comparator_power_off_o;
    logic             irq_o;
    int               errors = 0;
    int               cmp_count = 0;
    logic [7:0]       d;
    logic [1:0]       m;
    logic [1:0]       modes [4] = '{MODE_TOGGLE, MODE_FALL, MODE_RISE, MODE_RSVD};
    // Pads all high, so the port bits are the inverse of the disable bits.
    acc_row_t         rows [9] = '{
        '{2'h0, 8'hff, 8'hcb, 6'h3f}, '{2'h0, 8'h00, 8'h00, 6'h3f},
        '{2'h1, 8'hff, 8'h47, 6'h3f}, '{2'h1, 8'h00, 8'h00, 6'h3f},
        '{2'h2, 8'hff, 8'h3f, 6'h00}, '{2'h2, 8'h15, 8'h15, 6'h2a},
        '{2'h2, 8'h2a, 8'h2a, 6'h15}, '{2'h3, 8'hff, 8'h00, 6'h15},
        '{2'h2, 8'h00, 8'h00, 6'h3f}};

    always #20 clk_i = ~clk_i;

    acc_ctrl acc_ctrl_inst (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pos_pin_i(pos_pin_i),
        .neg_pin_i(neg_pin_i), .chan_i(chan_i), .converter_enable_i(converter_enable_i),
        .channel_select_low_i(channel_select_low_i),
        .reference_level_select_i(reference_level_select_i),
        .global_irq_en_i(global_irq_en_i), .irq_vector_ack_i(irq_vector_ack_i),
        .pad_in_i(pad_in_i), .port_in_o(port_in_o), .buf_off_o(buf_off_o),
        .comparator_power_off_o(comparator_power_off_o), .irq_o(irq_o));

    // ==========================================================
    // Bus and check tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Strobes drop at the taking edge, so a following call cannot double-drive them.
    task automatic wr(input logic [1:0] a, input logic [7:0] w);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= w;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] a, output logic [7:0] q);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        q = rdata_o;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
    endtask

    task automatic lvl(input logic [9:0] p, input logic [9:0] n);
        @(posedge clk_i);
        pos_pin_i <= p;
        neg_pin_i <= n;
    endtask

    task automatic res(input logic e);
        rd(REG_CMP_CSR, d);
        chk({7'h00, d[BIT_RESULT]}, {7'h00, e});
    endtask

    task automatic summarize;
        $display("errors=%0d comparisons=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ==========================================================
    // Watchdog: a hang counts as a mismatch.
    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        summarize();
    end

    // ==========================================================
    // Main sequence
    initial begin
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            rd(2'(k), d);
            chk(d, 8'h00);
        end
        chk({7'h00, irq_o}, 8'h00);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a, d);
            chk(d, rows[i].r);
            chk({2'b00, port_in_o}, {2'b00, rows[i].p});
            chk({2'b00, buf_off_o}, {2'b00, ~rows[i].p});
        end
        cyc(1);
        chk(rdata_o, 8'h00);
        foreach (modes[i]) begin
            m = modes[i];
            wr(REG_CMP_CSR, 8'h10);
            wr(REG_CMP_CSR, 8'h08 | {6'h00, m});
            lvl(10'h300, 10'h200);
            cyc(4);
            chk({7'h00, irq_o}, {7'h00, m == MODE_TOGGLE || m == MODE_RISE});
            @(posedge clk_i);
            irq_vector_ack_i <= 1'b1;
            @(posedge clk_i);
            irq_vector_ack_i <= 1'b0;
            cyc(1);
            chk({7'h00, irq_o}, 8'h00);
            lvl(10'h100, 10'h200);
            cyc(4);
            rd(REG_CMP_CSR, d);
            chk({7'h00, d[BIT_EVT_FLAG]}, {7'h00, m == MODE_TOGGLE || m == MODE_FALL});
            wr(REG_CMP_CSR, 8'h18 | {6'h00, m});
            cyc(1);
            chk({7'h00, irq_o}, 8'h00);
        end
        wr(REG_CMP_CSR, 8'h10);
        wr(REG_CMP_CSR, 8'h0b);
        lvl(10'h300, 10'h200);
        cyc(1);
        chk({7'h00, irq_o}, 8'h00);
        cyc(2);
        chk({7'h00, irq_o}, 8'h01);
        wr(REG_CMP_CSR, 8'h1b);
        cyc(5);
        chk({7'h00, irq_o}, 8'h00);
        lvl(10'h100, 10'h200);
        cyc(4);
        @(posedge clk_i);
        global_irq_en_i <= 1'b0;
        lvl(10'h300, 10'h200);
        cyc(4);
        chk({7'h00, irq_o}, 8'h00);
        @(posedge clk_i);
        global_irq_en_i <= 1'b1;
        cyc(1);
        chk({7'h00, irq_o}, 8'h01);
        wr(REG_CMP_CSR, 8'h03);
        cyc(1);
        chk({7'h00, irq_o}, 8'h00);
        rd(REG_CMP_CSR, d);
        chk({7'h00, d[BIT_EVT_FLAG]}, 8'h01);
        wr(REG_CMP_CSR, 8'h80);
        cyc(3);
        chk({7'h00, comparator_power_off_o}, 8'h01);
        res(1'b0);
        wr(REG_CMP_CSR, 8'h00);
        cyc(3);
        res(1'b1);
        wr(REG_CMP_CSR, 8'h40);
        lvl(10'h000, 10'h200);
        @(posedge clk_i);
        reference_level_select_i <= 3'b010;
        cyc(3);
        res(1'b1);
        @(posedge clk_i);
        reference_level_select_i <= 3'b000;
        cyc(3);
        res(1'b0);
        wr(REG_CMP_CSR, 8'h00);
        wr(REG_CONV_B, 8'h40);
        lvl(10'h200, 10'h3ff);
        for (int c = 0; c < 4; c++) begin
            @(posedge clk_i);
            channel_select_low_i <= 2'(c);
            cyc(3);
            res(10'h200 > chan_i[c]);
        end
        @(posedge clk_i);
        converter_enable_i <= 1'b1;
        cyc(3);
        res(1'b0);
        // Reset in mid-run must clear every register, after which the pads pass to the port bits.
        wr(REG_CMP_CSR, 8'h80);
        wr(REG_IN_DIS, 8'h3f);
        @(posedge clk_i);
        sys_rst_i <= 1'b1;
        pad_in_i <= 6'h15;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        cyc(1);
        chk({7'h00, comparator_power_off_o}, 8'h00);
        chk({2'b00, port_in_o}, 8'h15);
        chk({2'b00, buf_off_o}, 8'h00);
        for (int k = 0; k < 3; k++) begin
            rd(2'(k), d);
            chk(d, 8'h00);
        end
        summarize();
    end
endmodule
`default_nettype wire
